// ### hw/tmu_match_unit.sv
// Purpose: one comparator match unit with optional event counter
// Assumes: trigger bits are synchronous to clk_i
// Notes:   event_o is registered, one cycle after the sample it judges

module tmu_match_unit #(
  parameter int unsigned         W     = 8,
  parameter tmu_pkg::tmu_mtype_t MTYPE = tmu_pkg::MT_BASIC,
  parameter int unsigned         CNT_W = 0
) (
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  input  wire logic                               ce_i,
  input  wire logic                               clr_i,
  input  wire logic [W-1:0]                       trig_i,
  input  wire logic [W*tmu_pkg::TMU_CODE_W-1:0]   code_i,
  input  wire logic [W-1:0]                       hi_i,
  input  wire logic [tmu_pkg::TMU_FUNC_W-1:0]     func_i,
  input  wire logic [tmu_pkg::TMU_MAX_CNT_W-1:0]  cnt_i,
  output logic                                    event_o
);
  import tmu_pkg::*;

  // ********************************************************************
  // capabilities of this type
  // ********************************************************************
  localparam bit HAS_EDGE = (MTYPE == MT_BASIC_EDGE) ||
                            (MTYPE == MT_EXT_EDGE) ||
                            (MTYPE == MT_RANGE_EDGE);
  localparam bit HAS_MAG  = (MTYPE != MT_BASIC) &&
                            (MTYPE != MT_BASIC_EDGE);
  localparam bit HAS_RNG  = (MTYPE == MT_RANGE) ||
                            (MTYPE == MT_RANGE_EDGE);

  logic [W-1:0] prev;
  logic [W-1:0] care;
  logic [W-1:0] val;
  logic [W-1:0] edge_ok;
  logic         cmp;
  logic         raw;
  logic         fire;

  // transition test on one bit; non-edge codes always pass
  function automatic logic edge_hit(input logic [2:0] c, input logic p,
                                    input logic q);
    case (c)
      BV_RISE: return !p && q;
      BV_FALL: return p && !q;
      BV_ANY:  return p ^ q;
      BV_NONE: return !(p ^ q);
      default: return 1'b1;
    endcase
  endfunction

  // per-bit decode; edge codes act as don't-care on types without edges
  for (genvar i = 0; i < W; i++) begin : g_bit
    wire logic [2:0] c = code_i[i*TMU_CODE_W +: TMU_CODE_W];
    assign care[i] = (c == BV_ZERO) || (c == BV_ONE);
    assign val[i]  = (c == BV_ONE);
    assign edge_ok[i] = !HAS_EDGE || edge_hit(c, prev[i], trig_i[i]);
  end

  // don't-care bits are masked on both sides before any magnitude test
  wire logic [W-1:0] cur_m = trig_i & care;
  wire logic [W-1:0] lo_m  = val & care;
  wire logic [W-1:0] hi_m  = hi_i & care;
  wire logic         eq    = (cur_m == lo_m);
  wire logic         gt    = (cur_m > lo_m);
  wire logic         in_r  = (cur_m >= lo_m) && (cur_m <= hi_m);

  // function select; a function the type lacks never matches
  always_comb begin
    case (func_i)
      FN_EQ:   cmp = eq;
      FN_NE:   cmp = !eq;
      FN_GT:   cmp = HAS_MAG && gt;
      FN_GE:   cmp = HAS_MAG && (gt || eq);
      FN_LT:   cmp = HAS_MAG && !gt && !eq;
      FN_LE:   cmp = HAS_MAG && !gt;
      FN_IN:   cmp = HAS_RNG && in_r;
      FN_OUT:  cmp = HAS_RNG && !in_r;
      default: cmp = 1'b0;
    endcase
  end

  assign raw = cmp && (&edge_ok);

  // ********************************************************************
  // optional event counter
  // ********************************************************************
  if (CNT_W > 0) begin : g_cnt
    logic [CNT_W-1:0] cnt;
    wire  logic [CNT_W-1:0] tgt      = cnt_i[CNT_W-1:0];
    wire  logic [CNT_W-1:0] next_cnt = cnt + 1'b1;
    // target 0 or 1 fires on every match; count restarts after firing
    assign fire = raw && ((next_cnt >= tgt) || (cnt == '1));
    always_ff @(posedge clk_i) begin
      if (rst_i || (ce_i && clr_i)) cnt <= '0;
      else if (ce_i && raw) cnt <= fire ? '0 : next_cnt;
    end
  end else begin : g_nocnt
    assign fire = raw;
  end

  // previous sample kept for transition detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev    <= '0;
      event_o <= 1'b0;
    end else if (ce_i) begin
      prev    <= trig_i;
      event_o <= fire;
    end
  end

endmodule

// ### hw/tmu_pkg.sv
// Purpose: shared constants, types and helpers of the trigger match units
// Assumes: one core clock, all inputs synchronous to it
// Notes:   port widths, match counts and data widths are generation
//          parameters; helpers here turn them into offsets and limits

package tmu_pkg;

  // ********************************************************************
  // limits and timing
  // ********************************************************************
  localparam int unsigned TMU_MAX_PORTS  = 16;
  localparam int unsigned TMU_MAX_MU     = 16;
  localparam int unsigned TMU_MAX_W      = 256;
  localparam int unsigned TMU_MAX_CNT_W  = 32;
  localparam int unsigned TMU_MAX_DATA_W = 4096;
  localparam int unsigned TMU_MAX_LEVELS = 16;
  localparam int unsigned TMU_TRIG_LAT   = 10;   // input to trigger out
  localparam int unsigned TMU_CODE_W     = 3;
  localparam int unsigned TMU_FUNC_W     = 4;
  localparam int unsigned TMU_IDX_W      = 4;

  // ********************************************************************
  // per-bit value codes
  // ********************************************************************
  localparam logic [2:0] BV_ZERO = 3'h0;
  localparam logic [2:0] BV_ONE  = 3'h1;
  localparam logic [2:0] BV_DC   = 3'h2;
  localparam logic [2:0] BV_RISE = 3'h3;
  localparam logic [2:0] BV_FALL = 3'h4;
  localparam logic [2:0] BV_ANY  = 3'h5;
  localparam logic [2:0] BV_NONE = 3'h6;

  // ********************************************************************
  // match functions
  // ********************************************************************
  localparam logic [3:0] FN_EQ  = 4'h0;
  localparam logic [3:0] FN_NE  = 4'h1;
  localparam logic [3:0] FN_GT  = 4'h2;
  localparam logic [3:0] FN_GE  = 4'h3;
  localparam logic [3:0] FN_LT  = 4'h4;
  localparam logic [3:0] FN_LE  = 4'h5;
  localparam logic [3:0] FN_IN  = 4'h6;
  localparam logic [3:0] FN_OUT = 4'h7;

  typedef enum {MT_BASIC, MT_BASIC_EDGE, MT_EXT, MT_EXT_EDGE,
                MT_RANGE, MT_RANGE_EDGE} tmu_mtype_t;

  typedef int unsigned tmu_arr_t [TMU_MAX_PORTS];

  // ********************************************************************
  // helpers
  // ********************************************************************
  // sum of the first n entries
  function automatic int unsigned tmu_sum_upto(input tmu_arr_t a,
                                               input int unsigned n);
    int unsigned s;
    s = 0;
    for (int i = 0; i < TMU_MAX_PORTS; i++) begin
      if (i < n) s += a[i];
    end
    return s;
  endfunction

  // clamp every entry into lo..hi
  function automatic tmu_arr_t tmu_clamp_arr(input tmu_arr_t a,
                                             input int unsigned lo,
                                             input int unsigned hi);
    tmu_arr_t r;
    r = a;
    for (int i = 0; i < TMU_MAX_PORTS; i++) begin
      r[i] = (a[i] < lo) ? lo : ((a[i] > hi) ? hi : a[i]);
    end
    return r;
  endfunction

  // stored width per port; a port that would overflow the word is dropped
  function automatic tmu_arr_t tmu_data_widths(
      input tmu_arr_t w, input logic [TMU_MAX_PORTS-1:0] excl,
      input int unsigned n);
    tmu_arr_t r;
    int unsigned s;
    s = 0;
    for (int i = 0; i < TMU_MAX_PORTS; i++) begin
      r[i] = 0;
      if (i < n && !excl[i] && s + w[i] <= TMU_MAX_DATA_W) begin
        r[i] = w[i];
        s += w[i];
      end
    end
    return r;
  endfunction

  // boolean and/or of the selected match events; empty mask never fires
  function automatic logic tmu_combine(input logic [TMU_MAX_MU-1:0] ev,
                                       input logic [TMU_MAX_MU-1:0] mask,
                                       input logic use_or);
    if (use_or) return |(ev & mask);
    return (|mask) && (&(ev | ~mask));
  endfunction

endpackage

// ### hw/tmu_trigger_core.sv
// Purpose: trigger front end of a capture core: ports, match units,
//          trigger condition, sequencer, qualification and data word
// Assumes: TRIG_I is driven from logic on the core clock, unused bits 0
// Notes:   all run-time settings are plain ports, sampled every cycle
//
// Overview of operation
// - each trigger port one to 256 bits
// - one to sixteen match units per port
// - at most sixteen match units in total
// - match events combine into one trigger condition
// - optional per-unit counter, 1-32 bits, run-time target
// - counter disabled by default, then not built
// - six unit types, one type per port
// - basic: 0/1/X bits, equal and not-equal
// - basic with edges adds R/F/B/N bits
// - extended adds magnitude comparisons
// - extended with edges: magnitude plus transitions
// - range adds in-range and not-in-range
// - range with edges adds transition bit values
// - ports stored in data word unless excluded
// - stored data word at most 4096 bits
// - sequencer up to sixteen levels, run-time selects
// - trigger out lags ten cycles, cleared on rearm/upload
// - storage qualification as boolean of events
// - rising or falling clock edge, generation choice

module tmu_trigger_core #(
  parameter  int unsigned         NUM_PORTS  = 1,
  parameter  tmu_pkg::tmu_arr_t   PORT_W     = '{default: 8},
  parameter  tmu_pkg::tmu_arr_t   PORT_MU    = '{default: 1},
  parameter  tmu_pkg::tmu_arr_t   PORT_CNT_W = '{default: 0},
  parameter  tmu_pkg::tmu_mtype_t PORT_TYPE [tmu_pkg::TMU_MAX_PORTS] =
                                  '{default: tmu_pkg::MT_BASIC},
  parameter  logic [tmu_pkg::TMU_MAX_PORTS-1:0] PORT_EXCL = 16'h0000,
  parameter  bit                  SAMPLE_FALL = 1'b0,
  localparam tmu_pkg::tmu_arr_t   TW_C = tmu_pkg::tmu_clamp_arr(
                                    PORT_W, 1, tmu_pkg::TMU_MAX_W),
  localparam int unsigned         TRIG_TW =
                                    tmu_pkg::tmu_sum_upto(TW_C, NUM_PORTS),
  localparam tmu_pkg::tmu_arr_t   DW = tmu_pkg::tmu_data_widths(
                                    TW_C, PORT_EXCL, NUM_PORTS),
  localparam int unsigned         DSUM =
                                    tmu_pkg::tmu_sum_upto(DW, NUM_PORTS),
  localparam int unsigned         DATA_TW = (DSUM == 0) ? 1 : DSUM
) (
  input  wire logic                        MCLK_I,
  input  wire logic                        SRST_I,
  input  wire logic                        CE_I,
  input  wire logic [TRIG_TW-1:0]          TRIG_I,
  input  wire logic                        ARM_I,
  input  wire logic                        UPLOAD_I,
  input  wire logic [tmu_pkg::TMU_MAX_MU*tmu_pkg::TMU_MAX_W*
                     tmu_pkg::TMU_CODE_W-1:0] MU_CODE_I,
  input  wire logic [tmu_pkg::TMU_MAX_MU*tmu_pkg::TMU_MAX_W-1:0] MU_HI_I,
  input  wire logic [tmu_pkg::TMU_MAX_MU*tmu_pkg::TMU_FUNC_W-1:0]
                                           MU_FUNC_I,
  input  wire logic [tmu_pkg::TMU_MAX_MU*tmu_pkg::TMU_MAX_CNT_W-1:0]
                                           MU_CNT_I,
  input  wire logic [tmu_pkg::TMU_MAX_MU-1:0] COND_MASK_I,
  input  wire logic                        COND_OR_I,
  input  wire logic                        SEQ_EN_I,
  input  wire logic [tmu_pkg::TMU_IDX_W-1:0] SEQ_LAST_I,
  input  wire logic                        SEQ_CONTIG_I,
  input  wire logic [tmu_pkg::TMU_MAX_LEVELS*tmu_pkg::TMU_IDX_W-1:0]
                                           SEQ_SEL_I,
  input  wire logic                        QUAL_EN_I,
  input  wire logic [tmu_pkg::TMU_MAX_MU-1:0] QUAL_MASK_I,
  input  wire logic                        QUAL_OR_I,
  input  wire logic                        TRIG_PULSE_I,
  input  wire logic                        TRIG_INV_I,
  output logic                             TRIG_O,
  output logic                             ARMED_O,
  output logic                             TRIGGERED_O,
  output logic [tmu_pkg::TMU_IDX_W-1:0]    SEQ_LEVEL_O,
  output logic [tmu_pkg::TMU_MAX_MU-1:0]   MATCH_O,
  output logic [DATA_TW-1:0]               DATA_O,
  output logic                             DATA_VALID_O
);
  import tmu_pkg::*;

  // ********************************************************************
  // generation-time bookkeeping
  // ********************************************************************
  localparam tmu_arr_t    MU_C     = tmu_clamp_arr(PORT_MU, 1,
                                                   TMU_MAX_MU);
  localparam int unsigned MU_SUM   = tmu_sum_upto(MU_C, NUM_PORTS);
  localparam int unsigned MU_TOTAL = (MU_SUM > TMU_MAX_MU) ?
                                     TMU_MAX_MU : MU_SUM;
  localparam int unsigned PIPE_N   = TMU_TRIG_LAT - 2;

  // sampling edge chosen once; falling edge inverts the core clock
  wire logic core_clk = MCLK_I ^ SAMPLE_FALL;

  logic [TMU_MAX_MU-1:0] ev;
  logic [TRIG_TW-1:0]    d1;
  logic [DATA_TW-1:0]    data_word;
  logic [PIPE_N-1:0]     pipe;
  logic                  lvl;
  logic                  armed;
  logic                  triggered;
  logic [TMU_IDX_W-1:0]  seq_level;

  // ********************************************************************
  // match units, numbered across ports in port order
  // ********************************************************************
  for (genvar p = 0; p < TMU_MAX_PORTS; p++) begin : g_port
    if (p < NUM_PORTS) begin : g_on
      localparam int unsigned TOFF = tmu_sum_upto(TW_C, p);
      localparam int unsigned W    = TW_C[p];
      localparam int unsigned CW   = (PORT_CNT_W[p] > TMU_MAX_CNT_W) ?
                                     TMU_MAX_CNT_W : PORT_CNT_W[p];
      for (genvar m = 0; m < TMU_MAX_MU; m++) begin : g_mu
        localparam int unsigned IDX = tmu_sum_upto(MU_C, p) + m;
        // units past the core total are simply not built
        if (m < MU_C[p] && IDX < TMU_MAX_MU) begin : g_inst
          tmu_match_unit #(
            .W     (W),
            .MTYPE (PORT_TYPE[p]),
            .CNT_W (CW)
          ) u_mu (
            .clk_i   (core_clk),
            .rst_i   (SRST_I),
            .ce_i    (CE_I),
            .clr_i   (ARM_I),
            .trig_i  (TRIG_I[TOFF +: W]),
            .code_i  (MU_CODE_I[IDX*TMU_MAX_W*TMU_CODE_W +:
                                W*TMU_CODE_W]),
            .hi_i    (MU_HI_I[IDX*TMU_MAX_W +: W]),
            .func_i  (MU_FUNC_I[IDX*TMU_FUNC_W +: TMU_FUNC_W]),
            .cnt_i   (MU_CNT_I[IDX*TMU_MAX_CNT_W +: TMU_MAX_CNT_W]),
            .event_o (ev[IDX])
          );
        end
      end
    end
  end

  // unused event slots read as never matching
  for (genvar g = MU_TOTAL; g < TMU_MAX_MU; g++) begin : g_tie
    assign ev[g] = 1'b0;
  end

  assign MATCH_O = ev;                         // straight from unit flops

  // ********************************************************************
  // trigger condition and sequencer
  // ********************************************************************
  // the sequencer is cyclic: it returns to level 0 once it fires
  wire logic [TMU_IDX_W-1:0] seq_sel =
    SEQ_SEL_I[seq_level*TMU_IDX_W +: TMU_IDX_W];
  wire logic seq_hit    = ev[seq_sel];
  wire logic seq_at_end = (seq_level == SEQ_LAST_I);
  wire logic hunting    = armed && !triggered;
  wire logic bool_hit   = tmu_combine(ev, COND_MASK_I, COND_OR_I);
  wire logic cond_hit   = SEQ_EN_I ? (seq_hit && seq_at_end) : bool_hit;
  wire logic fire       = hunting && cond_hit;
  wire logic clr_out    = ARM_I || UPLOAD_I;

  // next sequencer level; contiguous mode drops back on a missed step
  logic [TMU_IDX_W-1:0] next_level;
  always_comb begin
    next_level = seq_level;
    if (ARM_I) begin
      next_level = '0;
    end else if (SEQ_EN_I && hunting) begin
      if (seq_hit) begin
        next_level = seq_at_end ? '0 : seq_level + 1'b1;
      end else if (SEQ_CONTIG_I) begin
        next_level = '0;
      end
    end
  end

  // arm and trigger status; a trigger in the rearm cycle still shows
  always_ff @(posedge core_clk) begin
    if (SRST_I) begin
      armed     <= 1'b0;
      triggered <= 1'b0;
      seq_level <= '0;
    end else if (CE_I) begin
      armed     <= ARM_I || (armed && !fire);
      triggered <= fire || (triggered && !ARM_I);
      seq_level <= next_level;
    end
  end

  assign ARMED_O     = armed;
  assign TRIGGERED_O = triggered;
  assign SEQ_LEVEL_O = seq_level;

  // ********************************************************************
  // trigger output
  // ********************************************************************
  // fixed delay line so the output lags the inputs by a known amount;
  // in-flight events are not flushed by a rearm, they arrive late
  wire logic pipe_last = pipe[PIPE_N-1];
  wire logic next_lvl  = pipe_last || (lvl && !clr_out);
  wire logic next_act  = TRIG_PULSE_I ? pipe_last : next_lvl;

  always_ff @(posedge core_clk) begin
    if (SRST_I) begin
      pipe   <= '0;
      lvl    <= 1'b0;
      TRIG_O <= 1'b0;
    end else if (CE_I) begin
      pipe   <= {pipe[PIPE_N-2:0], fire};
      lvl    <= next_lvl;
      TRIG_O <= next_act ^ TRIG_INV_I;
    end
  end

  // ********************************************************************
  // shared trigger data word and storage qualification
  // ********************************************************************
  // data is delayed one cycle so it lines up with the match events
  for (genvar p = 0; p < TMU_MAX_PORTS; p++) begin : g_data
    if (p < NUM_PORTS && DW[p] > 0) begin : g_inc
      localparam int unsigned TOFF = tmu_sum_upto(TW_C, p);
      localparam int unsigned DOFF = tmu_sum_upto(DW, p);
      assign data_word[DOFF +: DW[p]] = d1[TOFF +: DW[p]];
    end
  end
  if (DSUM == 0) begin : g_nodata
    assign data_word = '0;
  end

  wire logic qual_hit = tmu_combine(ev, QUAL_MASK_I, QUAL_OR_I);

  always_ff @(posedge core_clk) begin
    if (SRST_I) begin
      d1           <= '0;
      DATA_O       <= '0;
      DATA_VALID_O <= 1'b0;
    end else if (CE_I) begin
      d1           <= TRIG_I;
      DATA_O       <= data_word;
      DATA_VALID_O <= QUAL_EN_I ? qual_hit : 1'b1;
    end
  end

endmodule

// ### verif/tb_trigger_match_units.sv
// Purpose: directed tests of the trigger match units
// Assumes: two ports, 8-bit extended-edge and 4-bit range, port 1 excluded
// Notes:   match and trigger pulses are counted at the falling edge
module tb_trigger_match_units;
  import tmu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst = 1, arm = 0, upl = 0, pls = 0, seq = 0, qen = 0, ld = 0;
  logic ce = 1, cor = 1, inv = 0;
  logic [11:0] nv = '0, trig;
  logic [12287:0] code = '0;
  logic [4095:0] hi = '0;
  logic [511:0] cnt = '0;
  logic [63:0] fn = '0, sel = '0;
  logic [15:0] cm = '0, qm = '0, mo;
  logic [3:0] last = '0, lvl;
  logic [7:0] dout;
  logic to, armed, trgd, dv;
  int n_errors = 0, check_count = 0, hits = 0, thits = 0, sel_i = 0, cyc = 0;
  logic [7:0] exp_r [2] = '{8'h4e, 8'h69};
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  tmu_user_model #(.W(12)) u_user (.clk_i(clk), .ld_i(ld), .val_i(nv),
    .sig_o(trig));
  // settings come from this bench alone, one control source
  tmu_trigger_core #(.NUM_PORTS(2), .PORT_W('{0: 8, 1: 4, default: 1}),
    .PORT_MU('{0: 2, default: 1}), .PORT_CNT_W('{0: 4, default: 0}),
    .PORT_TYPE('{0: MT_EXT_EDGE, 1: MT_RANGE, default: MT_BASIC}),
    .PORT_EXCL(16'h0002)) dut (.MCLK_I(clk), .SRST_I(rst), .CE_I(ce),
    .TRIG_I(trig), .ARM_I(arm), .UPLOAD_I(upl), .MU_CODE_I(code),
    .MU_HI_I(hi), .MU_FUNC_I(fn), .MU_CNT_I(cnt), .COND_MASK_I(cm),
    .COND_OR_I(cor), .SEQ_EN_I(seq), .SEQ_LAST_I(last), .SEQ_CONTIG_I(1'b0),
    .SEQ_SEL_I(sel), .QUAL_EN_I(qen), .QUAL_MASK_I(qm), .QUAL_OR_I(cor),
    .TRIG_PULSE_I(pls), .TRIG_INV_I(inv), .TRIG_O(to), .ARMED_O(armed),
    .TRIGGERED_O(trgd), .SEQ_LEVEL_O(lvl), .MATCH_O(mo), .DATA_O(dout),
    .DATA_VALID_O(dv));
  // ******************************************
  // helpers
  // ******************************************
  // pulses are counted mid-cycle, where outputs have settled
  always @(negedge clk) begin
    if (mo[sel_i]) hits++;
    if (to ^ inv) thits++;
  end
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic put(logic [11:0] v);
    @(posedge clk) ld <= 1;
    nv <= v;
    @(posedge clk) ld <= 0;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse_arm();
    @(posedge clk) arm <= 1;
    @(posedge clk) arm <= 0;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ******************************************
  // tests
  // ******************************************
  initial begin
    tick(5);
    rst <= 0;
    tick(2);
    chk("armed", armed, 0);
    chk("trig", to, 0);
    // range unit 2: bound 3..9, probed inside and at the lower edge
    code[1536 +: 12] <= {BV_ZERO, BV_ZERO, BV_ONE, BV_ONE};
    hi[512 +: 4] <= 4'h9;
    for (int v = 0; v < 2; v++) begin
      put(v ? 12'h300 : 12'h500);
      for (int f = 0; f < 8; f++) begin
        fn[8 +: 4] <= f[3:0];
        tick(4);
        chk("range fn", mo[2], exp_r[v][f]);
      end
    end
    // unit 0: rise on bit 0, counter targets 1 and 3 over six rises
    code[2:0] <= BV_RISE;
    for (int t = 1; t < 4; t += 2) begin
      cnt[31:0] <= t;
      tick(2);
      hits = 0;
      repeat (6) begin
        put(12'h001);
        put(12'h000);
      end
      tick(3);
      chk("rise events", hits, 6 / t);
    end
    cnt[31:0] <= 1;
    // boolean trigger on unit 2, level then pulse shape
    fn[8 +: 4] <= FN_EQ;
    // second pass: inverted pulse, and of unit 2 with unit 1, which matches while port 0 is zero
    for (int p = 0; p < 2; p++) begin
      pls <= p[0];
      inv <= p[0];
      cor <= !p[0];
      cm  <= p[0] ? 16'h0006 : 16'h0004;
      put(12'h000);
      pulse_arm();
      tick(2);
      chk("armed", armed, 1);
      thits = 0;
      put(12'h300);
      tick(14);
      chk("triggered", {armed, trgd}, 2'b01);
      chk("trig shape", p ? thits : to, 1);
      put(12'h000);
      put(12'h300);
      tick(12);
      chk("no retrigger", thits, p ? 1 : 20);
      @(posedge clk) upl <= 1;
      @(posedge clk) upl <= 0;
      tick(2);
      chk("trig cleared", to, p);
    end
    // stored word: port 0 only; qualified by unit 2
    put(12'h3a5);
    tick(3);
    chk("data", dout, 8'ha5);
    // enable low: the stored word must hold although the port moves
    ce <= 0;
    put(12'h35a);
    tick(3);
    chk("ce freeze", dout, 8'ha5);
    ce <= 1;
    qen <= 1;
    qm <= 16'h0004;
    tick(3);
    chk("qual on", dv, 1);
    put(12'h0a5);
    tick(3);
    chk("qual off", dv, 0);
    // two-level sequence: unit 2, then a rise on unit 0
    seq <= 1;
    last <= 4'h1;
    sel[7:0] <= 8'h02;
    put(12'h000);
    pulse_arm();
    put(12'h300);
    tick(3);
    chk("seq level", {lvl, trgd}, 5'h02);
    put(12'h301);
    tick(3);
    chk("seq fire", trgd, 1);
    print_verdict();
  end
endmodule

// ### verif/tmu_checker.sv
// Purpose: port-level assertions of the trigger match units
// Assumes: port 0 leads the stored word, rising-edge sampling
// Notes:   bound to tmu_trigger_core below
module tmu_checker #(
  parameter int unsigned TRIG_TW = 12,
  parameter int unsigned DATA_TW = 8
) (
  input wire logic               MCLK_I,
  input wire logic               SRST_I,
  input wire logic               CE_I,
  input wire logic [TRIG_TW-1:0] TRIG_I,
  input wire logic               ARM_I,
  input wire logic               UPLOAD_I,
  input wire logic [15:0]        COND_MASK_I,
  input wire logic               COND_OR_I,
  input wire logic               SEQ_EN_I,
  input wire logic               TRIG_PULSE_I,
  input wire logic               TRIG_INV_I,
  input wire logic               TRIG_O,
  input wire logic               ARMED_O,
  input wire logic               TRIGGERED_O,
  input wire logic [3:0]         SEQ_LEVEL_O,
  input wire logic [15:0]        MATCH_O,
  input wire logic [DATA_TW-1:0] DATA_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  // ******************************************
  // trigger timing
  // ******************************************
  // fire step seen first on the sticky flag, the output eight edges on
  sequence s_fire;
    $rose(TRIGGERED_O);
  endsequence
  chk_trig_lag: assert property (s_fire |-> ##8 (TRIG_O != TRIG_INV_I))
    else $error("trigger output lag wrong");
  chk_armed_drop: assert property (s_fire ##0 !$past(ARM_I) |-> !ARMED_O)
    else $error("armed flag stayed after trigger");
  chk_arm_sets: assert property (CE_I && ARM_I |=> ARMED_O && SEQ_LEVEL_O == 4'h0)
    else $error("rearm did not reset state");
  chk_trig_sticky: assert property (TRIGGERED_O && !ARM_I |=> TRIGGERED_O)
    else $error("triggered flag dropped without rearm");
  chk_bool_fire: assert property (CE_I && !SEQ_EN_I && COND_OR_I &&
    |(MATCH_O & COND_MASK_I) && ARMED_O && !TRIGGERED_O |=> TRIGGERED_O)
    else $error("condition met but no trigger");
  chk_pulse_one: assert property (TRIG_PULSE_I && !TRIG_INV_I && TRIG_O
    |=> !TRIG_O) else $error("pulse output longer than a cycle");
  chk_level_hold: assert property (!TRIG_PULSE_I && !TRIG_INV_I && TRIG_O
    && CE_I && !ARM_I && !UPLOAD_I |=> TRIG_O)
    else $error("level output cleared too early");
  // hazard: word only valid once two clean edges have passed reset
  chk_data_lag: assert property ($past(CE_I) && $past(CE_I, 2) &&
    !$past(SRST_I) && !$past(SRST_I, 2) |->
    DATA_O == $past(TRIG_I[DATA_TW-1:0], 2))
    else $error("stored word does not follow trigger port");
endmodule

bind tmu_trigger_core tmu_checker #(.TRIG_TW(TRIG_TW), .DATA_TW(DATA_TW))
  u_chk (.MCLK_I(MCLK_I), .SRST_I(SRST_I), .CE_I(CE_I), .TRIG_I(TRIG_I),
  .ARM_I(ARM_I), .UPLOAD_I(UPLOAD_I), .COND_MASK_I(COND_MASK_I),
  .COND_OR_I(COND_OR_I), .SEQ_EN_I(SEQ_EN_I), .TRIG_PULSE_I(TRIG_PULSE_I),
  .TRIG_INV_I(TRIG_INV_I), .TRIG_O(TRIG_O), .ARMED_O(ARMED_O),
  .TRIGGERED_O(TRIGGERED_O), .SEQ_LEVEL_O(SEQ_LEVEL_O), .MATCH_O(MATCH_O),
  .DATA_O(DATA_O));

// ### verif/tmu_user_model.sv
// Purpose: observed user logic feeding the trigger ports
// Assumes: shares the core clock
// Notes:   value loads one edge after the request
module tmu_user_model #(
  parameter int unsigned W = 12
) (
  input  wire logic         clk_i,
  input  wire logic         ld_i,
  input  wire logic [W-1:0] val_i,
  output logic      [W-1:0] sig_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // unused bits start at zero, never floating
  initial sig_o = '0;
  // launched on the core clock only, so no synchronizer is needed
  always @(posedge clk_i) begin
    if (ld_i) sig_o <= val_i;
  end
endmodule
